/* mscn_pkg.sv */
// Purpose: shared constants and types for the modem status scanner
// Assumes: 20 MHz hclk, AHB-Lite register access, 32-bit data
// Notes: register offsets are byte addresses of aligned words
package mscn_pkg;
  // ********************************************************
  // clock and scan timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 50;               // hclk period
  localparam int SCAN_LINE_NS = 1200;              // time spent on one line
  localparam int SCAN_CYCLES = (SCAN_LINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_LINES = 16;                   // modem lines served
  localparam int PTR_W = 4;                        // channel pointer width
  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [4:0] OFS_CTRL = 5'h00;         // scan control and pointer
  localparam logic [4:0] OFS_LINE = 5'h04;         // leads of the pointed line
  localparam logic [4:0] OFS_STAT = 5'h08;         // sticky events, write one clears
  localparam logic [4:0] OFS_MASK = 5'h0C;         // interrupt mask
  // control register fields
  localparam int CTRL_SCAN_EN = 0;                 // free-running scan
  localparam int CTRL_STEP = 1;                    // write one: scan one line
  localparam int CTRL_IRQ_ALLOW = 2;               // global interrupt enable
  localparam int CTRL_CLR_SCAN = 3;                // write one: pointer to zero
  localparam int CTRL_PTR_LSB = 8;                 // channel pointer field
  // line register fields
  localparam int LINE_TERM_RDY = 0;                // terminal ready out
  localparam int LINE_RTS = 1;                     // request to send out
  localparam int LINE_BACK_OUT = 2;                // backchannel out
  localparam int LINE_EN = 3;                      // per-line enable
  localparam int LINE_LIVE_LSB = 4;                // live inputs, four bits
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] MASK_RESET = 16'hFFFF;
  // fixed bus request level
  localparam logic [2:0] IRQ_LEVEL = 3'h4;
  // ********************************************************
  // types
  // ********************************************************
  typedef struct packed {
    logic ring;                                    // ring indicator
    logic carrier_detect;                          // carrier
    logic cts;                                     // clear to send
    logic backchannel_in;                          // secondary receive
  } mscn_lead_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_CMP = 2'b10,
    ST_ADV = 2'b11
  } mscn_state_t;
endpackage

/* mscn_tick.sv */
// Purpose: scan rate divider, one-cycle enable per line slot
// Assumes: single clock hclk
// Notes: acts as the internally clocked ring counter
`timescale 1ns/1ps
`default_nettype none
module mscn_tick import mscn_pkg::*; #(
  parameter int CYCLES = SCAN_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // enable pulse out
  output logic tick
);
  // ********************************************************
  // divider
  // ********************************************************
  logic [7:0] cnt; // cycles into the slot
  // count up, pulse on wrap
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end
    else if (cnt == 8'(CYCLES - 1))
    begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // mscn_tick
`default_nettype wire

/* mscn_hold_mem.sv */
// Purpose: per-line store of last known incoming lead state
// Assumes: one write and one registered read port
// Notes: contents undefined after reset, valid bits live outside
`timescale 1ns/1ps
`default_nettype none
module mscn_hold_mem import mscn_pkg::*; #(
  parameter int DEPTH = NUM_LINES
) (
  // clock
  input wire logic hclk,
  // write port
  input wire logic we,
  input wire logic [PTR_W-1:0] waddr,
  input wire mscn_lead_t wdata,
  // read port
  input wire logic [PTR_W-1:0] raddr,
  output mscn_lead_t rdata
);
  // ********************************************************
  // storage
  // ********************************************************
  mscn_lead_t mem [DEPTH]; // one entry per line
  // write, no reset so it maps to ram
  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
  // registered read
  always_ff @(posedge hclk)
  begin
    rdata <= mem[raddr];
  end
endmodule // mscn_hold_mem
`default_nettype wire

/* mscn_scanner.sv */
// Purpose: sixteen-line modem control lead scanner with AHB-Lite registers
// Assumes: modem inputs are asynchronous and synchronised here
// Notes: transitions are seen only on the line the pointer visits
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mscn_scanner import mscn_pkg::*; #(
  parameter int LINES = NUM_LINES,
  parameter int SCAN_CYC = SCAN_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // modem inputs, asynchronous
  input wire logic [LINES-1:0] ring_in,
  input wire logic [LINES-1:0] carrier_detect,
  input wire logic [LINES-1:0] cts_in,
  input wire logic [LINES-1:0] backchannel_in,
  // modem outputs
  output logic [LINES-1:0] term_rdy,
  output logic [LINES-1:0] rts_out,
  output logic [LINES-1:0] backchannel_out,
  // interrupt
  output logic irq,
  output logic [2:0] irq_level
);
  // ********************************************************
  // input synchronisers
  // ********************************************************
  mscn_lead_t [LINES-1:0] sync1; // first stage, read only by sync2
  mscn_lead_t [LINES-1:0] sync2; // safe copy of the modem leads
  // two flops per lead before any logic looks at it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      for (int i = 0; i < LINES; i++)
      begin
        sync1[i] <= '{ring_in[i], carrier_detect[i], cts_in[i], backchannel_in[i]};
      end
      sync2 <= sync1;
    end
  end
  // ********************************************************
  // bus address phase capture
  // ********************************************************
  logic dp_wr; // write pending in data phase
  logic [4:0] dp_addr; // word offset of that write
  logic acc; // address phase accepted this cycle
  assign acc = hsel && hready && htrans[1];
  // always zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr <= 1'b0;
      dp_addr <= 5'h00;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_wr <= acc && hwrite;
      dp_addr <= {haddr[4:2], 2'b00};
    end
  end
  // write strobes for each register
  logic wr_ctrl; // data phase write to control
  logic wr_line; // data phase write to line leads
  logic wr_stat; // data phase write-one-clear
  logic wr_mask; // data phase write to mask
  assign wr_ctrl = dp_wr && (dp_addr == OFS_CTRL);
  assign wr_line = dp_wr && (dp_addr == OFS_LINE);
  assign wr_stat = dp_wr && (dp_addr == OFS_STAT);
  assign wr_mask = dp_wr && (dp_addr == OFS_MASK);
  // ********************************************************
  // control state
  // ********************************************************
  logic scan_en; // free-run scan
  logic irq_allow; // global interrupt enable
  logic step_pend; // one line step requested
  logic [PTR_W-1:0] channel_pointer; // line being served
  logic [15:0] stat; // sticky per-line events
  logic [15:0] mask; // per-line interrupt mask
  logic [LINES-1:0] line_en; // per-line enable
  logic [LINES-1:0] hold_valid; // holding store entry written once
  mscn_state_t state; // scan sequencer state
  logic [PTR_W-1:0] cur_line; // line latched for this slot
  logic tick; // slot enable from the ring counter
  logic advance; // pointer moves this cycle
  logic set_evt; // transition seen on cur_line
  mscn_lead_t live; // live leads of cur_line
  mscn_lead_t held; // held leads of cur_line
  // scan enable bits and step request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scan_en <= CTRL_RESET[CTRL_SCAN_EN];
      irq_allow <= CTRL_RESET[CTRL_IRQ_ALLOW];
      step_pend <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        scan_en <= hwdata[CTRL_SCAN_EN];
        irq_allow <= hwdata[CTRL_IRQ_ALLOW];
      end
      // a new step request wins over consuming the old one
      if (wr_ctrl && hwdata[CTRL_STEP])
        step_pend <= 1'b1;
      else if (advance)
        step_pend <= 1'b0;
    end
  end
  // pointer: software load wins over the scan advance
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      channel_pointer <= '0;
    else if (wr_ctrl && hwdata[CTRL_CLR_SCAN])
      channel_pointer <= '0;
    else if (wr_ctrl)
      channel_pointer <= hwdata[CTRL_PTR_LSB +: PTR_W];
    else if (advance)
      channel_pointer <= PTR_W'(channel_pointer + 1'b1);
  end
  // ********************************************************
  // scan sequencer
  // ********************************************************
  mscn_tick #(.CYCLES(SCAN_CYC)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );
  // step mode advances only when a step is pending
  assign advance = (state == ST_ADV) && !(wr_ctrl) && (scan_en || step_pend);
  // read, compare, advance, one pass per slot
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_IDLE;
      cur_line <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // slot starts only while the scan is enabled or a step is pending
          if (tick && (scan_en || step_pend))
          begin
            state <= ST_READ;
            cur_line <= channel_pointer;
          end
        end
        ST_READ: state <= ST_CMP;
        ST_CMP: state <= ST_ADV;
        ST_ADV: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end
  // ********************************************************
  // transition detection
  // ********************************************************
  mscn_hold_mem #(.DEPTH(LINES)) u_hold ( // last known leads per line
    .hclk(hclk),
    .we(state == ST_CMP), // held value follows live after compare
    .waddr(cur_line),
    .wdata(live),
    .raddr(cur_line),
    .rdata(held)
  );
  // live leads of the latched line
  assign live = sync2[cur_line];
  // any changed lead, ring rising included, gated by enables
  assign set_evt = (state == ST_CMP) && hold_valid[cur_line] && (live != held)
                   && line_en[cur_line] && irq_allow;
  // first visit only primes the holding store
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_valid <= '0;
    else if (state == ST_CMP)
      hold_valid[cur_line] <= 1'b1;
  end
  // sticky status, set wins over write-one-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat <= 16'h0000;
    end
    else
    begin
      stat <= (stat & ~(wr_stat ? hwdata[15:0] : 16'h0000))
              | (set_evt ? (16'h0001 << cur_line) : 16'h0000);
    end
  end
  // mask register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask <= MASK_RESET;
    else if (wr_mask)
      mask <= hwdata[15:0];
  end
  // level interrupt and fixed request level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
      irq_level <= 3'h0;
    end
    else
    begin
      irq <= |(stat & mask);
      irq_level <= IRQ_LEVEL;
    end
  end
  // ********************************************************
  // outgoing leads
  // ********************************************************
  // only the pointed line takes the written leads
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      term_rdy <= '0;
      rts_out <= '0;
      backchannel_out <= '0;
      line_en <= '0;
    end
    else if (wr_line)
    begin
      term_rdy[channel_pointer] <= hwdata[LINE_TERM_RDY];
      rts_out[channel_pointer] <= hwdata[LINE_RTS];
      backchannel_out[channel_pointer] <= hwdata[LINE_BACK_OUT];
      line_en[channel_pointer] <= hwdata[LINE_EN];
    end
  end
  // ********************************************************
  // read data
  // ********************************************************
  logic [31:0] next_rdata; // value for the coming data phase
  // decode on the address phase, unmapped reads as zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case ({haddr[4:2], 2'b00})
      OFS_CTRL:
      begin
        next_rdata[CTRL_SCAN_EN] = scan_en;
        next_rdata[CTRL_STEP] = step_pend;
        next_rdata[CTRL_IRQ_ALLOW] = irq_allow;
        next_rdata[CTRL_PTR_LSB +: PTR_W] = channel_pointer;
      end
      OFS_LINE:
      begin
        next_rdata[LINE_TERM_RDY] = term_rdy[channel_pointer];
        next_rdata[LINE_RTS] = rts_out[channel_pointer];
        next_rdata[LINE_BACK_OUT] = backchannel_out[channel_pointer];
        next_rdata[LINE_EN] = line_en[channel_pointer];
        next_rdata[LINE_LIVE_LSB +: 4] = sync2[channel_pointer];
      end
      OFS_STAT: next_rdata[15:0] = stat;
      OFS_MASK: next_rdata[15:0] = mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end
  // hrdata comes from a flop, loaded at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (acc && !hwrite)
      hrdata <= next_rdata;
  end
  // ********************************************************
  // assertions
  // ********************************************************
  sequence s_slot;
    state == ST_READ ##1 state == ST_CMP ##1 state == ST_ADV;
  endsequence
  property p_level;
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> irq_level == IRQ_LEVEL;
  endproperty
  a_level: assert property (p_level) else $error("bad request level");
  property p_slot;
    @(posedge hclk) disable iff (!hresetn) (state == ST_IDLE && tick && (scan_en || step_pend))
      |=> s_slot;
  endproperty
  a_slot: assert property (p_slot) else $error("scan slot broken");
  property p_wrap;
    @(posedge hclk) disable iff (!hresetn) (advance && channel_pointer == 4'hF)
      |=> channel_pointer == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
  property p_hold;
    @(posedge hclk) disable iff (!hresetn) (state == ST_ADV && !advance && !wr_ctrl)
      |=> $stable(channel_pointer);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved in step mode");
  property p_gate;
    @(posedge hclk) disable iff (!hresetn) set_evt |-> irq_allow && line_en[cur_line];
  endproperty
  a_gate: assert property (p_gate) else $error("event without enables");
  property p_update;
    @(posedge hclk) disable iff (!hresetn) (state == ST_CMP) ##3 (state == ST_READ)
      && (cur_line == $past(cur_line, 3)) ##1 1'b1 |-> held == $past(live, 4);
  endproperty
  a_update: assert property (p_update) else $error("held value not updated");
  property p_sticky;
    @(posedge hclk) disable iff (!hresetn) (set_evt && mask[cur_line]) |=> ##1 irq;
  endproperty
  a_sticky: assert property (p_sticky) else $error("event gave no interrupt");
  property p_lead;
    @(posedge hclk) disable iff (!hresetn) wr_line
      |=> term_rdy[$past(channel_pointer)] == $past(hwdata[LINE_TERM_RDY]);
  endproperty
  a_lead: assert property (p_lead) else $error("lead not applied");
  property p_scan_gate;
    @(posedge hclk) disable iff (!hresetn) (state == ST_IDLE && !scan_en && !step_pend)
      |=> state == ST_IDLE;
  endproperty
  a_scan_gate: assert property (p_scan_gate) else $error("scan without enable");
endmodule // mscn_scanner
`default_nettype wire

/* mscn_modem_model.sv */
// Purpose: behavioural model of sixteen modems on the control leads
// Assumes: answer leads follow terminal ready after a fixed delay
// Notes: backchannel is looped back, ring is commanded by the bench
`timescale 1ns/1ps
`default_nettype none
module mscn_modem_model import mscn_pkg::*; #(
  parameter int LINES = NUM_LINES,
  parameter int DELAY = 6
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench command
  input wire logic [LINES-1:0] ring_cmd,
  // leads from the scanner
  input wire logic [LINES-1:0] term_rdy,
  input wire logic [LINES-1:0] backchannel_out,
  // leads to the scanner
  output logic [LINES-1:0] ring_in,
  output logic [LINES-1:0] carrier_detect,
  output logic [LINES-1:0] cts_in,
  output logic [LINES-1:0] backchannel_in
);
  // ****************************************
  // answer delay line
  // ****************************************
  logic [LINES-1:0] answer_pipe [DELAY]; // terminal ready history
  // cleared in reset so no unknown reaches the hold store
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      for (int k = 0; k < DELAY; k++)
        answer_pipe[k] <= '0;
    else
    begin
      answer_pipe[0] <= term_rdy;
      for (int k = 1; k < DELAY; k++)
        answer_pipe[k] <= answer_pipe[k-1];
    end
  end
  // link comes up some time after terminal ready
  assign carrier_detect = answer_pipe[DELAY-1];
  assign cts_in = answer_pipe[DELAY-1];
  assign ring_in = ring_cmd;
  assign backchannel_in = backchannel_out;
endmodule // mscn_modem_model
`default_nettype wire

/* mscn_scanner_bench.sv */
// Purpose: self-checking bench of the modem status scanner
// Assumes: zero-wait slave, short scan divider
// Notes: bench plays host software over ahb-lite
`timescale 1ns/1ps
`default_nettype none
module mscn_scanner_bench import mscn_pkg::*;;
  // ****************************************
  // signals and constants
  // ****************************************
  localparam logic [31:0] A_CTRL = 32'(OFS_CTRL);
  localparam logic [31:0] A_LINE = 32'(OFS_LINE);
  localparam logic [31:0] A_STAT = 32'(OFS_STAT);
  localparam logic [31:0] A_MASK = 32'(OFS_MASK);
  localparam int REV = 300; // a full revolution with slack
  typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] e;} mscn_row_t;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, irq_level;
  logic [15:0] ring_in, carrier_detect, cts_in, backchannel_in;
  logic [15:0] term_rdy, rts_out, backchannel_out, ring_cmd, exp_r, exp_b;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // register cases: address, write value, read-back
  mscn_row_t rows [5] = '{
    '{A_MASK, 32'hFFFF_A5A5, 32'h0000_A5A5},
    '{A_CTRL, 32'h0000_0F04, 32'h0000_0F04},
    '{32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000},
    '{A_MASK, 32'h0000_FFFF, 32'h0000_FFFF},
    '{A_STAT, 32'h0000_FFFF, 32'h0000_0000}};
  always #25 hclk = ~hclk;
  mscn_scanner #(.LINES(16), .SCAN_CYC(4)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ring_in(ring_in), .carrier_detect(carrier_detect),
    .cts_in(cts_in), .backchannel_in(backchannel_in), .term_rdy(term_rdy),
    .rts_out(rts_out), .backchannel_out(backchannel_out), .irq(irq),
    .irq_level(irq_level));
  mscn_modem_model #(.LINES(16), .DELAY(6)) modems (.hclk(hclk), .hresetn(hresetn),
    .ring_cmd(ring_cmd), .term_rdy(term_rdy), .backchannel_out(backchannel_out),
    .ring_in(ring_in), .carrier_detect(carrier_detect), .cts_in(cts_in),
    .backchannel_in(backchannel_in));
  // ****************************************
  // tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single transfer, entered just after a rising edge
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask
  task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    chk(n, e, x);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // hang guard, about three times the expected run
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      conclude();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    ring_cmd = '0;
    cycles(3);
    hresetn <= 1'b1;
    cycles(2);
    chk("irq_level", 32'(IRQ_LEVEL), 32'(irq_level));
    chk("hresp", 32'h0, 32'(hresp));
    chk("hreadyout", 32'h1, 32'(hreadyout));
    rd("ctrl", A_CTRL, CTRL_RESET);
    rd("mask", A_MASK, 32'(MASK_RESET));
    rd("stat", A_STAT, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd("row", rows[i].a, rows[i].e);
    end
    // per-line outputs, line five left disabled
    for (int i = 0; i < 16; i++)
    begin
      wr(A_CTRL, 32'(i) << CTRL_PTR_LSB | 32'h4);
      wr(A_LINE, ((i != 5) ? 32'h8 : 32'h0) | 32'(i & 6));
      exp_r[i] = i[1];
      exp_b[i] = i[2];
    end
    @(negedge hclk);
    chk("rts", 32'(exp_r), 32'(rts_out));
    chk("back_out", 32'(exp_b), 32'(backchannel_out));
    @(posedge hclk);
    // first revolution only primes the store
    wr(A_CTRL, 32'h5);
    cycles(REV);
    rd("stat", A_STAT, 32'h0);
    ring_cmd[3] <= 1'b1;
    cycles(REV);
    rd("stat", A_STAT, 32'h8);
    @(negedge hclk);
    chk("irq", 32'h1, 32'(irq));
    @(posedge hclk);
    // answer the ring: halt scan, raise terminal ready
    wr(A_CTRL, 32'h0304);
    wr(A_LINE, 32'hB);
    wr(A_STAT, 32'h8);
    rd("stat", A_STAT, 32'h0);
    cycles(20);
    rd("line", A_LINE, 32'hEB);
    chk("term_rdy", 32'h8, 32'(term_rdy));
    wr(A_CTRL, 32'h0305);
    cycles(REV);
    rd("stat", A_STAT, 32'h8);
    wr(A_MASK, 32'hFFF7);
    // irq is a register, it follows the mask one edge later
    @(posedge hclk);
    @(negedge hclk);
    chk("irq", 32'h0, 32'(irq));
    @(posedge hclk);
    wr(A_MASK, 32'hFFFF);
    wr(A_STAT, 32'hFFFF);
    // global enable off, then only enabled lines report
    wr(A_CTRL, 32'h1);
    ring_cmd[3] <= 1'b0;
    cycles(REV);
    rd("stat", A_STAT, 32'h0);
    wr(A_CTRL, 32'h5);
    ring_cmd[6:5] <= 2'b11;
    cycles(REV);
    rd("stat", A_STAT, 32'h40);
    // originate on line nine: terminal ready first, then await the answer
    wr(A_STAT, 32'hFFFF);
    wr(A_CTRL, 32'h0904);
    wr(A_LINE, 32'h9);
    wr(A_CTRL, 32'h0905);
    cycles(REV);
    rd("stat", A_STAT, 32'h0200);
    // step mode from the top line wraps to zero
    wr(A_CTRL, 32'h0F04);
    cycles(50);
    rd("ctrl", A_CTRL, 32'h0F04);
    ring_cmd[15] <= 1'b1;
    wr(A_STAT, 32'hFFFF);
    wr(A_CTRL, 32'h0F06);
    cycles(50);
    rd("ctrl", A_CTRL, 32'h0004);
    rd("stat", A_STAT, 32'h8000);
    wr(A_CTRL, 32'h0A0C);
    rd("ctrl", A_CTRL, 32'h0004);
    // reset in mid-run
    hresetn <= 1'b0;
    @(negedge hclk);
    chk("term_rdy", 32'h0, 32'(term_rdy));
    chk("irq", 32'h0, 32'(irq));
    @(posedge hclk);
    hresetn <= 1'b1;
    cycles(2);
    rd("mask", A_MASK, 32'(MASK_RESET));
    chk("irq_level", 32'(IRQ_LEVEL), 32'(irq_level));
    conclude();
  end
endmodule // mscn_scanner_bench
`default_nettype wire
